// File: rtl/ckm_clock_mode_ctrl.sv
// Clock generator mode control with oscillator range controls behind an AXI4-Lite slave.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ckm_defines.svh"
// Functional notes
// - Max-tune bit 5 picks default 25% range or maximum-frequency tuning.
// - Range status shows the oscillator range only after synchronisation.
// - Range status reads zero in both low-power bypass modes and both PLL modes.
// - Range select 0 is low range, 1 is mid range.
// - Range select writes are ignored while low-power or loop select is set.
// - Factor is 512, 608, 1024 or 1216 from range and tuning.
// - Source select %10 switches the system clock to the external reference.
// - Source select %01 switches to the internal reference, bypassed internal mode.
// - Clock status bits 3:2 show the clock really feeding the output.
// - Low-power set from PLL-bypassed external gives low-power external; clearing leaves it.
// - Loop select clear picks the FLL; code %011 with divide-by-32 set then divides 256.
// - Divide-by-32 bit remaps the divider to the FLL ratio.
// - With loop select clear the VCO divider has no effect.
// - In low-power external mode a loop select change waits until low power is cleared.
// - Loop status flag bit 5 clears once the FLL is the loop source.
// - The FLL keeps running in the bypass modes without low power, and stops in both low-power modes; lock flag is bit 6.
module ckm_clock_mode_ctrl
    import ckm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_range_ind,
    input wire logic fll_lock_ind,
    input wire logic [1:0] mux_source_ind,
    output logic [1:0] clock_source_select,
    output logic internal_ref_sel,
    output logic low_power_bypass,
    output logic pll_loop_active,
    output logic range_select,
    output logic max_tune_sel,
    output logic [10:0] fll_mult,
    output logic [12:0] ref_div_ratio,
    output logic [3:0] vco_div_out,
    output logic fll_enable,
    output ckm_mode_t clock_mode
);
    ckm_state_t st_r;
    ckm_state_t st_nxt;

    logic [3:0] sync_out;
    logic range_sync;
    logic lock_sync;
    logic [1:0] src_status;
    logic range_view;

    logic [10:0] mult_dec;
    logic [12:0] div_dec;

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane0;

    // Oscillator range, lock and mux status come from outside the bus clock domain.
    ckm_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({mux_source_ind, fll_lock_ind, osc_range_ind}),
        .stable_out(sync_out)
    );

    // Split of the synchronised status bits.
    assign range_sync = sync_out[0];
    assign lock_sync = sync_out[1];
    assign src_status = sync_out[3:2];

    // Ratio decode from the current register state.
    ckm_ratio u_ratio (
        .range_sel(st_r.range_sel),
        .max_tune(st_r.max_tune),
        .rcode(st_r.rcode),
        .fll_sel(!st_r.pll_eff),
        .d32_sel(st_r.d32_sel),
        .mult(mult_dec),
        .refdiv(div_dec)
    );

    // Mode reached from the source select, low-power bit and effective loop choice.
    function automatic ckm_mode_t mode_of(input logic [1:0] cs, input logic iref,
                                          input logic lowp, input logic pll,
                                          input ckm_mode_t cur);
        case (cs)
            2'h0: mode_of = pll ? CKM_PENG : (iref ? CKM_FEI : CKM_FEE);
            `CKM_CS_INT: mode_of = lowp ? CKM_LPINT : CKM_FBINT;
            `CKM_CS_EXT: mode_of = lowp ? CKM_LPEXT : (pll ? CKM_PBEXT : CKM_FBEXT);
            default: mode_of = cur;
        endcase
    endfunction

    // Range status is not valid in the bypassed low-power and PLL modes.
    assign range_view = (st_r.mode == CKM_LPINT || st_r.mode == CKM_LPEXT ||
                         st_r.mode == CKM_PBEXT || st_r.mode == CKM_PENG) ? 1'b0 : range_sync;

    // Bus handshakes; each channel is refused while its word or response is pending.
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    // A write takes effect once address and data are both held, in either order.
    assign do_write = (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs) && !st_r.bvalid;
    assign wr_addr = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
    assign wr_data = st_r.w_got ? st_r.wdata : s_axi_wdata[7:0];
    assign wr_lane0 = st_r.w_got ? st_r.wlane0 : s_axi_wstrb[0];

    // Next-state logic for bus slave, register file and mode tracking.
    always_comb begin
        st_nxt = st_r;
        if (aw_hs) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wlane0 = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `CKM_RESP_OKAY;
            case (wr_addr)
                `CKM_OFF_CTRL1: begin
                    if (wr_lane0) begin
                        st_nxt.clk_src = wr_data[`CKM_CTRL1_CS_HI:`CKM_CTRL1_CS_LO];
                        st_nxt.rcode = wr_data[`CKM_CTRL1_RCODE_HI:`CKM_CTRL1_RCODE_LO];
                        st_nxt.int_ref = wr_data[`CKM_CTRL1_IREF];
                    end
                end
                `CKM_OFF_CTRL2: begin
                    if (wr_lane0) begin
                        st_nxt.lowp = wr_data[`CKM_CTRL2_LOWP];
                    end
                end
                `CKM_OFF_CTRL3: begin
                    if (wr_lane0) begin
                        st_nxt.pll_sel = wr_data[`CKM_CTRL3_PLLSEL];
                        st_nxt.d32_sel = wr_data[`CKM_CTRL3_D32SEL];
                        st_nxt.vcod = wr_data[`CKM_CTRL3_VCOD_HI:`CKM_CTRL3_VCOD_LO];
                    end
                end
                `CKM_OFF_STATUS: begin
                    st_nxt.bresp = `CKM_RESP_OKAY;
                end
                `CKM_OFF_TEST: begin
                    // Test bits 5 and 0 are stored; range select only while low power and loop select are clear.
                    if (wr_lane0) begin
                        st_nxt.max_tune = wr_data[`CKM_TEST_MAXTUNE];
                        if (!st_r.lowp && !st_r.pll_sel) begin
                            st_nxt.range_sel = wr_data[`CKM_TEST_RANGE];
                        end
                    end
                end
                default: begin
                    st_nxt.bresp = `CKM_RESP_SLVERR;
                end
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `CKM_RESP_OKAY;
            case (s_axi_araddr)
                `CKM_OFF_CTRL1: st_nxt.rdata = {st_r.clk_src, st_r.rcode, st_r.int_ref, 2'h0};
                `CKM_OFF_CTRL2: st_nxt.rdata = {4'h0, st_r.lowp, 3'h0};
                `CKM_OFF_CTRL3: st_nxt.rdata = {1'b0, st_r.pll_sel, 1'b0, st_r.d32_sel, st_r.vcod};
                `CKM_OFF_STATUS: begin
                    st_nxt.rdata = {1'b0, lock_sync, st_r.pll_eff, 1'b0, src_status, 2'h0};
                end
                `CKM_OFF_TEST: st_nxt.rdata = {2'h0, st_r.max_tune, 4'h0, range_view};
                default: begin
                    st_nxt.rdata = 8'h00;
                    st_nxt.rresp = `CKM_RESP_SLVERR;
                end
            endcase
        end
        // In low power the loop choice is only prepared; it applies once low power is left.
        if (!st_r.lowp) begin
            st_nxt.pll_eff = st_r.pll_sel;
        end
        st_nxt.mode = mode_of(st_r.clk_src, st_r.int_ref, st_r.lowp, st_r.pll_eff, st_r.mode);
        st_nxt.mult = mult_dec;
        st_nxt.refdiv = div_dec;
        st_nxt.vco_out = st_r.pll_eff ? st_r.vcod : 4'h0;
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.clk_src <= 2'(`CKM_RST_CTRL1 >> `CKM_CTRL1_CS_LO);
            st_r.rcode <= 3'(`CKM_RST_CTRL1 >> `CKM_CTRL1_RCODE_LO);
            st_r.int_ref <= 1'(`CKM_RST_CTRL1 >> `CKM_CTRL1_IREF);
            st_r.lowp <= 1'(`CKM_RST_CTRL2 >> `CKM_CTRL2_LOWP);
            st_r.pll_sel <= 1'(`CKM_RST_CTRL3 >> `CKM_CTRL3_PLLSEL);
            st_r.d32_sel <= 1'(`CKM_RST_CTRL3 >> `CKM_CTRL3_D32SEL);
            st_r.vcod <= 4'(`CKM_RST_CTRL3);
            st_r.max_tune <= 1'(`CKM_RST_TEST >> `CKM_TEST_MAXTUNE);
            st_r.range_sel <= 1'(`CKM_RST_TEST);
            st_r.mode <= CKM_FEI;
            st_r.mult <= `CKM_MULT_LOW_DEF;
            st_r.refdiv <= 13'h0001;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus outputs and clock controls, all from the state register.
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign clock_source_select = st_r.clk_src;
    assign internal_ref_sel = st_r.int_ref;
    assign low_power_bypass = st_r.lowp;
    assign pll_loop_active = st_r.pll_eff;
    assign range_select = st_r.range_sel;
    assign max_tune_sel = st_r.max_tune;
    assign fll_mult = st_r.mult;
    assign ref_div_ratio = st_r.refdiv;
    assign vco_div_out = st_r.vco_out;
    assign fll_enable = !st_r.lowp || st_r.clk_src == 2'h0;
    assign clock_mode = st_r.mode;

    a_range_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_hs && s_axi_araddr == `CKM_OFF_TEST &&
         st_r.mode inside {CKM_LPINT, CKM_LPEXT, CKM_PBEXT, CKM_PENG}) |=> !s_axi_rdata[0])
        else $error("range status not zero in bypass mode");

    a_range_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && wr_addr == `CKM_OFF_TEST && (st_r.lowp || st_r.pll_sel))
        |=> $stable(st_r.range_sel))
        else $error("range select changed while locked");

    a_mult_mid: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.range_sel && st_r.max_tune) ##1 (st_r.range_sel && st_r.max_tune)
        |=> fll_mult == 11'h4c0)
        else $error("mid tuned factor wrong");

    a_fll_div: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st_r.pll_eff && st_r.d32_sel && st_r.rcode == 3'h3) |=> ref_div_ratio == 13'h0100)
        else $error("fll divider not 256");

    a_vco_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.pll_eff |=> vco_div_out == 4'h0)
        else $error("vco divider used with fll");

    a_src_ext: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && wr_addr == `CKM_OFF_CTRL1 && wr_lane0 && wr_data[7:6] == 2'h2)
        |=> clock_source_select == 2'h2 ##1 (st_r.lowp || clock_mode != CKM_FEI))
        else $error("external source not selected");

    a_lowp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.lowp && $stable(st_r.lowp)) |=> $stable(st_r.pll_eff))
        else $error("loop choice changed in low power");

    a_pll_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_hs && s_axi_araddr == `CKM_OFF_STATUS) |=> s_axi_rvalid && s_axi_rdata[5] == $past(st_r.pll_eff))
        else $error("loop status flag wrong");

    // Bus answer, ratio, source and loop checks.
    a_bus_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write answer missing");

    a_mult_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st_r.range_sel && !st_r.max_tune) |=> fll_mult == 11'h200)
        else $error("low default factor wrong");

    a_pll_div: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.pll_eff && st_r.rcode == 3'h3) |=> ref_div_ratio == 13'h0008)
        else $error("pll divider not 8");

    a_vco_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.pll_eff |=> vco_div_out == $past(st_r.vcod))
        else $error("vco divider not passed");

    a_src_int: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && wr_addr == `CKM_OFF_CTRL1 && wr_lane0 && wr_data[7:6] == 2'h1)
        |=> clock_source_select == 2'h1)
        else $error("internal source not selected");

    a_mode_int: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.clk_src == `CKM_CS_INT && !st_r.lowp) |=> clock_mode == CKM_FBINT)
        else $error("internal bypass mode missing");

    a_lock_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_hs && s_axi_araddr == `CKM_OFF_STATUS) |=> s_axi_rdata[6] == $past(lock_sync))
        else $error("lock flag wrong");

    a_fll_run: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.lowp |-> fll_enable)
        else $error("fll stopped while bypassed");
endmodule

// File: rtl/ckm_defines.svh
// Register offsets, field positions, reset values and fixed counts of the clock mode control.
`ifndef CKM_DEFINES_SVH
`define CKM_DEFINES_SVH
`define CKM_OFF_CTRL1 8'h00
`define CKM_OFF_CTRL2 8'h04
`define CKM_OFF_CTRL3 8'h08
`define CKM_OFF_STATUS 8'h0c
`define CKM_OFF_TEST 8'h10
`define CKM_CTRL1_CS_HI 7
`define CKM_CTRL1_CS_LO 6
`define CKM_CTRL1_RCODE_HI 5
`define CKM_CTRL1_RCODE_LO 3
`define CKM_CTRL1_IREF 2
`define CKM_CTRL2_LOWP 3
`define CKM_CTRL3_PLLSEL 6
`define CKM_CTRL3_D32SEL 4
`define CKM_CTRL3_VCOD_HI 3
`define CKM_CTRL3_VCOD_LO 0
`define CKM_STAT_LOCK 6
`define CKM_STAT_PLLFLG 5
`define CKM_STAT_CST_HI 3
`define CKM_STAT_CST_LO 2
`define CKM_TEST_MAXTUNE 5
`define CKM_TEST_RANGE 0
`define CKM_RST_CTRL1 8'h04
`define CKM_RST_CTRL2 8'h00
`define CKM_RST_CTRL3 8'h01
`define CKM_RST_TEST 8'h00
`define CKM_CS_EXT 2'h2
`define CKM_CS_INT 2'h1
`define CKM_MULT_LOW_DEF 11'h200
`define CKM_MULT_LOW_TUNE 11'h260
`define CKM_MULT_MID_DEF 11'h400
`define CKM_MULT_MID_TUNE 11'h4c0
`define CKM_FLL_DIV_SHIFT 4'h5
`define CKM_RESP_OKAY 2'h0
`define CKM_RESP_SLVERR 2'h2
`endif

// File: rtl/ckm_pkg.sv
// Types shared by the clock mode control modules.
package ckm_pkg;
    typedef enum logic [7:0] {
        CKM_FEI = 8'h01,
        CKM_FEE = 8'h02,
        CKM_FBINT = 8'h04,
        CKM_FBEXT = 8'h08,
        CKM_PBEXT = 8'h10,
        CKM_PENG = 8'h20,
        CKM_LPINT = 8'h40,
        CKM_LPEXT = 8'h80
    } ckm_mode_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] stable;
    } ckm_sync_t;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [1:0] clk_src;
        logic [2:0] rcode;
        logic int_ref;
        logic lowp;
        logic pll_sel;
        logic d32_sel;
        logic [3:0] vcod;
        logic max_tune;
        logic range_sel;
        logic pll_eff;
        ckm_mode_t mode;
        logic [10:0] mult;
        logic [12:0] refdiv;
        logic [3:0] vco_out;
    } ckm_state_t;
endpackage

// File: rtl/ckm_sync.sv
// Three-stage synchroniser with agreement filter for the oscillator-side status inputs.
`timescale 1ns/10ps
module ckm_sync
    import ckm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] async_in,
    output logic [3:0] stable_out
);
    ckm_sync_t st_r;
    ckm_sync_t st_nxt;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 4; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stable[i] = st_r.s3[i];
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stable_out = st_r.stable;
endmodule

// File: rtl/ckm_ratio.sv
// Loop multiplication factor and reference divider decode.
`timescale 1ns/10ps
`include "ckm_defines.svh"
module ckm_ratio
    import ckm_pkg::*;
(
    input wire logic range_sel,
    input wire logic max_tune,
    input wire logic [2:0] rcode,
    input wire logic fll_sel,
    input wire logic d32_sel,
    output logic [10:0] mult,
    output logic [12:0] refdiv
);
    // Factor chosen by range and tuning.
    function automatic logic [10:0] mult_of(input logic rs, input logic mt);
        case ({rs, mt})
            2'h0: mult_of = `CKM_MULT_LOW_DEF;
            2'h1: mult_of = `CKM_MULT_LOW_TUNE;
            2'h2: mult_of = `CKM_MULT_MID_DEF;
            default: mult_of = `CKM_MULT_MID_TUNE;
        endcase
    endfunction

    // The loop divides by two to the code; the frequency loop adds five more halvings when divide-by-32 is set.
    function automatic logic [12:0] div_of(input logic [2:0] code, input logic fll,
                                           input logic d32);
        logic [3:0] sh;
        sh = {1'b0, code};
        if (fll && d32) begin
            sh = sh + `CKM_FLL_DIV_SHIFT;
        end
        div_of = 13'h0001 << sh;
    endfunction

    // Combinational decode of both ratios.
    assign mult = mult_of(range_sel, max_tune);
    assign refdiv = div_of(rcode, fll_sel, d32_sel);
endmodule

// File: tb/fll_pll_clock_mode_control_tb_top.sv
// Self-checking testbench for the clock mode control with its AXI4-Lite register port.
`timescale 1ns/10ps
`include "ckm_defines.svh"
module fll_pll_clock_mode_control_tb_top
    import ckm_pkg::*;
;
    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, last_rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, last_bresp, last_rresp;
    logic osc_range_ind, fll_lock_ind;
    logic [1:0] mux_source_ind, clock_source_select;
    logic internal_ref_sel, low_power_bypass, pll_loop_active, range_select, max_tune_sel;
    logic [10:0] fll_mult;
    logic [12:0] ref_div_ratio;
    logic [3:0] vco_div_out;
    logic fll_enable;
    ckm_mode_t clock_mode;
    int err_total = 0;
    int checked = 0;
    int seed = 82886;
    logic [7:0] v;

    ckm_clock_mode_ctrl i_ckm_clock_mode_ctrl (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .osc_range_ind(osc_range_ind), .fll_lock_ind(fll_lock_ind),
        .mux_source_ind(mux_source_ind), .clock_source_select(clock_source_select),
        .internal_ref_sel(internal_ref_sel), .low_power_bypass(low_power_bypass),
        .pll_loop_active(pll_loop_active), .range_select(range_select),
        .max_tune_sel(max_tune_sel), .fll_mult(fll_mult), .ref_div_ratio(ref_div_ratio),
        .vco_div_out(vco_div_out), .fll_enable(fll_enable), .clock_mode(clock_mode)
    );

    // Free-running 100 MHz bus clock.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cuts a hung run short; the whole sequence needs well under this span.
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        test_done();
    end

    // Compares one value with case equality and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // One AXI4-Lite write; address and data are released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                last_bresp = bresp;
                bready <= 1'b0;
                n = 100;
            end
        end
        if (n != 100) begin
            err_total++;
            $display("Error write response missing at %h", a);
        end
    endtask

    // One AXI4-Lite read; the data are taken at the edge where rvalid is seen.
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                last_rdata = rdata;
                last_rresp = rresp;
                rready <= 1'b0;
                n = 100;
            end
        end
        if (n != 100) begin
            err_total++;
            $display("Error read response missing at %h", a);
        end
    endtask

    // Reads a register and compares the masked bits.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                          input string nm);
        rd(a);
        chk(nm, {24'h000000, e}, last_rdata & {24'h000000, m});
    endtask

    // Polls a register until the masked bits match, with a bounded number of reads.
    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string nm);
        int n;
        n = 0;
        rd(a);
        while (n < 30 && (last_rdata[7:0] & m) !== e) begin
            rd(a);
            n++;
        end
        chk(nm, {24'h000000, e}, last_rdata & {24'h000000, m});
    endtask

    // Expected loop factor from range select and max tune.
    function automatic logic [10:0] exp_mult(input logic rng, input logic tune);
        case ({rng, tune})
            2'b00: exp_mult = 11'h200;
            2'b01: exp_mult = 11'h260;
            2'b10: exp_mult = 11'h400;
            default: exp_mult = 11'h4c0;
        endcase
    endfunction

    // Main sequence: reset, factor table, range status, then the mode walk down to low power.
    initial begin
        aresetn = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; awprot = 3'h0; arprot = 3'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        wdata = 32'h00000000; wstrb = 4'h0;
        osc_range_ind = 1'b0; fll_lock_ind = 1'b0; mux_source_ind = 2'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wait_cyc(2);
        chk("reset clock_mode", CKM_FEI, clock_mode);
        chk("reset fll_mult", 32'h200, fll_mult);
        rd_chk(`CKM_OFF_CTRL1, 8'hff, `CKM_RST_CTRL1, "reset ctrl1");
        rd_chk(`CKM_OFF_CTRL3, 8'hff, `CKM_RST_CTRL3, "reset ctrl3");
        rd_chk(`CKM_OFF_TEST, 8'hff, `CKM_RST_TEST, "reset test");
        $display("Test reset done");
        // All four factor corners first, then random picks; reserved bits stay zero.
        for (int i = 0; i < 10; i++) begin
            v = (i < 4) ? {2'b00, i[1], 4'h0, i[0]} : 8'($random(seed) & 8'h21);
            wr(`CKM_OFF_TEST, v);
            wait_cyc(3);
            chk("fll_mult", exp_mult(v[0], v[5]), fll_mult);
            chk("range_select", v[0], range_select);
            chk("max_tune_sel", v[5], max_tune_sel);
        end
        $display("Test factor done");
        wr(`CKM_OFF_TEST, 8'h01);
        osc_range_ind <= 1'b1;
        wait_cyc(8);
        rd_chk(`CKM_OFF_TEST, 8'h01, 8'h01, "range status");
        $display("Test range status done");
        // Engage the loop in external mode.
        wr(`CKM_OFF_CTRL3, 8'h41);
        wr(`CKM_OFF_CTRL1, 8'h18);
        wait_cyc(3);
        chk("mode engaged", CKM_PENG, clock_mode);
        chk("pll active", 32'h1, pll_loop_active);
        chk("pll ref div", 32'h8, ref_div_ratio);
        rd_chk(`CKM_OFF_TEST, 8'h01, 8'h00, "range status engaged");
        wr(`CKM_OFF_TEST, 8'h00);
        wait_cyc(2);
        chk("range held pll", 32'h1, range_select);
        // Leave the engaged mode in the documented order.
        mux_source_ind <= 2'h2;
        wr(`CKM_OFF_CTRL1, 8'h98);
        wait_cyc(2);
        chk("source select ext", 32'h2, clock_source_select);
        poll(`CKM_OFF_STATUS, 8'h0c, 8'h08, "source status ext");
        chk("mode pll bypass", CKM_PBEXT, clock_mode);
        wr(`CKM_OFF_CTRL2, 8'h08);
        wait_cyc(3);
        chk("mode low power ext", CKM_LPEXT, clock_mode);
        chk("low power", 32'h1, low_power_bypass);
        rd_chk(`CKM_OFF_TEST, 8'h01, 8'h00, "range status low power ext");
        wr(`CKM_OFF_CTRL3, 8'h18);
        wait_cyc(3);
        chk("loop prepared only", 32'h1, pll_loop_active);
        chk("mode stays low power ext", CKM_LPEXT, clock_mode);
        wr(`CKM_OFF_TEST, 8'h00);
        wait_cyc(2);
        chk("range held low power", 32'h1, range_select);
        wr(`CKM_OFF_CTRL2, 8'h00);
        wait_cyc(3);
        chk("mode fll bypass ext", CKM_FBEXT, clock_mode);
        poll(`CKM_OFF_STATUS, 8'h20, 8'h00, "pll status clear");
        chk("fll ref div", 32'h100, ref_div_ratio);
        chk("vco div ignored", 32'h0, vco_div_out);
        fll_lock_ind <= 1'b1;
        wait_cyc(8);
        rd_chk(`CKM_OFF_STATUS, 8'h40, 8'h40, "lock flag");
        chk("fll enable", 32'h1, fll_enable);
        mux_source_ind <= 2'h1;
        wr(`CKM_OFF_CTRL1, 8'h5c);
        wait_cyc(3);
        chk("mode fll bypass int", CKM_FBINT, clock_mode);
        chk("internal ref", 32'h1, internal_ref_sel);
        chk("source select int", 32'h1, clock_source_select);
        wr(`CKM_OFF_CTRL2, 8'h08);
        wait_cyc(3);
        chk("mode low power int", CKM_LPINT, clock_mode);
        rd_chk(`CKM_OFF_TEST, 8'h01, 8'h00, "range status low power int");
        $display("Test mode walk done");
        // Unmapped places answer with an error and change nothing.
        wr(8'h14, 8'hff);
        chk("unmapped write resp", `CKM_RESP_SLVERR, last_bresp);
        rd(8'h14);
        chk("unmapped read resp", `CKM_RESP_SLVERR, last_rresp);
        chk("unmapped read data", 32'h0, last_rdata);
        wr(`CKM_OFF_STATUS, 8'hff);
        chk("status write resp", `CKM_RESP_OKAY, last_bresp);
        chk("mode after bus errors", CKM_LPINT, clock_mode);
        $display("Test bus errors done");
        test_done();
    end
endmodule
